/* src/cpurf_pkg.sv */
// Package of constants for the CPU register file
package cpurf_pkg;
    localparam int DATA_WIDTH = 32;
    localparam int GPR_INDEX_WIDTH = 5;
    localparam int SYS_INDEX_WIDTH = 5;
    localparam int GPR_COUNT = 32;
    // Dedicated general-purpose indices
    localparam logic [4:0] GPR_ZERO = 5'h00;
    localparam logic [4:0] GPR_HANDLER_STACK = 5'h02;
    localparam logic [4:0] GPR_STACK_POINTER = 5'h03;
    localparam logic [4:0] GPR_GLOBAL_POINTER = 5'h04;
    localparam logic [4:0] GPR_TEXT_POINTER = 5'h05;
    localparam logic [4:0] GPR_STR_DST_BIT = 5'h1a;
    localparam logic [4:0] GPR_STR_SRC_BIT = 5'h1b;
    localparam logic [4:0] GPR_STR_LENGTH = 5'h1c;
    localparam logic [4:0] GPR_STR_DST_ADDR = 5'h1d;
    localparam logic [4:0] GPR_STR_SRC_ADDR = 5'h1e;
    localparam logic [4:0] GPR_RETURN_LINK = 5'h1f;
    // System register numbers
    localparam logic [4:0] SYS_EXC_PC = 5'h00;
    localparam logic [4:0] SYS_EXC_STATUS = 5'h01;
    localparam logic [4:0] SYS_FATAL_PC = 5'h02;
    localparam logic [4:0] SYS_FATAL_STATUS = 5'h03;
    localparam logic [4:0] SYS_CAUSE = 5'h04;
    localparam logic [4:0] SYS_STATUS = 5'h05;
    localparam logic [4:0] SYS_IDENTITY = 5'h06;
    localparam logic [4:0] SYS_TASK_CTRL = 5'h07;
    localparam logic [4:0] SYS_CACHE_CTRL = 5'h18;
    localparam logic [4:0] SYS_ADDR_TRAP = 5'h19;
    // Reset values
    localparam logic [31:0] PC_RESET = 32'h0ffffff0;
    localparam logic [31:0] SYS_RESET = 32'h00000000;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    // Identity word: value is arbitrary
    localparam logic [31:0] IDENTITY_VALUE = 32'h00005a00;
endpackage

/* src/cpurf_gpr_mem.sv */
// Thirty-two word general-purpose storage with registered read ports
`timescale 1ns/1ps
module cpurf_gpr_mem (
    input wire logic mclk,
    input wire logic [4:0] rdAddrA,
    input wire logic [4:0] rdAddrB,
    output logic [31:0] rdDataA,
    output logic [31:0] rdDataB,
    input wire logic wrEn,
    input wire logic [4:0] wrAddr,
    input wire logic [31:0] wrData
);
    logic [31:0] store [0:31];

    // Write then registered read; old data returned on a same-cycle clash
    always_ff @(posedge mclk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
        rdDataA <= store[rdAddrA];
        rdDataB <= store[rdAddrB];
    end
endmodule // cpurf_gpr_mem

/* src/cpurf_register_file.sv */
// CPU architectural register file: GPRs, program counter, system registers
// How it works
// - Every register, the program counter included, is 32 bits wide.
// - Thirty-two general-purpose registers at indices 0 to 31 hold data or addresses.
// - Index 0 reads as zero, and indices 0 and 26 to 30 are also offered as implicit operands.
// - Bit-string operands come from indices 26 to 30 on dedicated outputs.
// - A jump-and-link writes its return address into index 31.
// - Program counter bit 0 is always zero.
// - Reset loads the program counter with 0ffffff0 hex.
// - Ten system registers hold save pairs, cause, status, identity, task, cache and trap.
// - An exception copies the program counter and status word into the exception save pair.
`timescale 1ns/1ps
module cpurf_register_file (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [4:0] readIndexA,
    input wire logic [4:0] readIndexB,
    output logic [31:0] readDataA,
    output logic [31:0] readDataB,
    input wire logic gprWriteEn,
    input wire logic [4:0] gprWriteIndex,
    input wire logic [31:0] gprWriteData,
    input wire logic jumpAndLinkOp,
    input wire logic [31:0] returnAddress,
    input wire logic pcLoadEn,
    input wire logic [31:0] pcLoadValue,
    output logic [31:0] programCounter,
    input wire logic exceptionTake,
    input wire logic fatalTake,
    input wire logic [31:0] causeValue,
    input wire logic sysWriteEn,
    input wire logic [4:0] sysWriteIndex,
    input wire logic [31:0] sysWriteData,
    input wire logic [4:0] sysReadIndex,
    output logic [31:0] sysReadData,
    output logic [31:0] programStatusWord,
    output logic [31:0] taskControlWord,
    output logic [31:0] cacheControlWord,
    output logic [31:0] addressTrapWord,
    output logic [31:0] strDstBitOffset,
    output logic [31:0] strSrcBitOffset,
    output logic [31:0] strLength,
    output logic [31:0] strDstAddress,
    output logic [31:0] strSrcAddress,
    output logic [31:0] zeroOperand
);
    logic [31:0] memDataA;
    logic [31:0] memDataB;
    logic zeroA_reg;
    logic zeroB_reg;
    logic [31:0] strDstBit_reg;
    logic [31:0] strSrcBit_reg;
    logic [31:0] strLen_reg;
    logic [31:0] strDstAddr_reg;
    logic [31:0] strSrcAddr_reg;
    logic [31:0] pc_reg;
    logic [31:0] pc_next;
    logic [31:0] excPc_reg;
    logic [31:0] excStatus_reg;
    logic [31:0] fatalPc_reg;
    logic [31:0] fatalStatus_reg;
    logic [31:0] cause_reg;
    logic [31:0] status_reg;
    logic [31:0] taskCtrl_reg;
    logic [31:0] cacheCtrl_reg;
    logic [31:0] addrTrap_reg;
    logic [31:0] sysRead_reg;
    logic [31:0] sysRead_next;

    // Combined write port: link write beats an ordinary write
    wire logic [4:0] portIndex = jumpAndLinkOp ? cpurf_pkg::GPR_RETURN_LINK
        : gprWriteIndex;
    wire logic [31:0] portData = jumpAndLinkOp ? returnAddress : gprWriteData;
    wire logic portEn = (jumpAndLinkOp || gprWriteEn)
        && (portIndex != cpurf_pkg::GPR_ZERO);
    wire logic sysWr = sysWriteEn && !exceptionTake && !fatalTake;

    function automatic logic sysHit(input logic [4:0] idx);
        sysHit = sysWr && (sysWriteIndex == idx);
    endfunction

    function automatic logic gprHit(input logic [4:0] idx);
        gprHit = portEn && (portIndex == idx);
    endfunction

    // Storage for all 32 general-purpose words
    cpurf_gpr_mem cpurf_gpr_mem_inst (
        .mclk(mclk),
        .rdAddrA(readIndexA),
        .rdAddrB(readIndexB),
        .rdDataA(memDataA),
        .rdDataB(memDataB),
        .wrEn(portEn),
        .wrAddr(portIndex),
        .wrData(portData)
    );

    // Flag zero-index reads so the port answers zero whatever the array holds
    always_ff @(posedge mclk) begin
        zeroA_reg <= (readIndexA == cpurf_pkg::GPR_ZERO);
        zeroB_reg <= (readIndexB == cpurf_pkg::GPR_ZERO);
    end

    assign readDataA = zeroA_reg ? cpurf_pkg::ZERO_WORD : memDataA;
    assign readDataB = zeroB_reg ? cpurf_pkg::ZERO_WORD : memDataB;
    assign zeroOperand = cpurf_pkg::ZERO_WORD;

    // Shadow copies of string operands, so the implicit ports need no read port
    always_ff @(posedge mclk) begin
        if (rst) begin
            strDstBit_reg <= cpurf_pkg::ZERO_WORD;
            strSrcBit_reg <= cpurf_pkg::ZERO_WORD;
            strLen_reg <= cpurf_pkg::ZERO_WORD;
            strDstAddr_reg <= cpurf_pkg::ZERO_WORD;
            strSrcAddr_reg <= cpurf_pkg::ZERO_WORD;
        end else begin
            if (gprHit(cpurf_pkg::GPR_STR_DST_BIT)) strDstBit_reg <= portData;
            if (gprHit(cpurf_pkg::GPR_STR_SRC_BIT)) strSrcBit_reg <= portData;
            if (gprHit(cpurf_pkg::GPR_STR_LENGTH)) strLen_reg <= portData;
            if (gprHit(cpurf_pkg::GPR_STR_DST_ADDR)) strDstAddr_reg <= portData;
            if (gprHit(cpurf_pkg::GPR_STR_SRC_ADDR)) strSrcAddr_reg <= portData;
        end
    end

    assign strDstBitOffset = strDstBit_reg;
    assign strSrcBitOffset = strSrcBit_reg;
    assign strLength = strLen_reg;
    assign strDstAddress = strDstAddr_reg;
    assign strSrcAddress = strSrcAddr_reg;

    // Bit 0 forced low so no load can produce an odd fetch address
    assign pc_next = pcLoadEn ? {pcLoadValue[31:1], 1'b0} : pc_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pc_reg <= cpurf_pkg::PC_RESET;
        end else begin
            pc_reg <= pc_next;
        end
    end

    assign programCounter = pc_reg;

    // Exception save pair; one pair only, nesting is software's problem
    always_ff @(posedge mclk) begin
        if (rst) begin
            excPc_reg <= cpurf_pkg::SYS_RESET;
            excStatus_reg <= cpurf_pkg::SYS_RESET;
        end else if (exceptionTake) begin
            excPc_reg <= pc_reg;
            excStatus_reg <= status_reg;
        end else begin
            if (sysHit(cpurf_pkg::SYS_EXC_PC)) excPc_reg <= {sysWriteData[31:1], 1'b0};
            if (sysHit(cpurf_pkg::SYS_EXC_STATUS)) excStatus_reg <= sysWriteData;
        end
    end

    // Fatal save pair, taken on a fatal error
    always_ff @(posedge mclk) begin
        if (rst) begin
            fatalPc_reg <= cpurf_pkg::SYS_RESET;
            fatalStatus_reg <= cpurf_pkg::SYS_RESET;
        end else if (fatalTake) begin
            fatalPc_reg <= pc_reg;
            fatalStatus_reg <= status_reg;
        end else begin
            if (sysHit(cpurf_pkg::SYS_FATAL_PC)) fatalPc_reg <= {sysWriteData[31:1], 1'b0};
            if (sysHit(cpurf_pkg::SYS_FATAL_STATUS)) fatalStatus_reg <= sysWriteData;
        end
    end

    // Cause follows any exception or fatal entry
    always_ff @(posedge mclk) begin
        if (rst) begin
            cause_reg <= cpurf_pkg::SYS_RESET;
        end else if (exceptionTake || fatalTake) begin
            cause_reg <= causeValue;
        end else if (sysHit(cpurf_pkg::SYS_CAUSE)) begin
            cause_reg <= sysWriteData;
        end
    end

    // Control words written only by system-register moves
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_reg <= cpurf_pkg::SYS_RESET;
            taskCtrl_reg <= cpurf_pkg::SYS_RESET;
            cacheCtrl_reg <= cpurf_pkg::SYS_RESET;
            addrTrap_reg <= cpurf_pkg::SYS_RESET;
        end else begin
            if (sysHit(cpurf_pkg::SYS_STATUS)) status_reg <= sysWriteData;
            if (sysHit(cpurf_pkg::SYS_TASK_CTRL)) taskCtrl_reg <= sysWriteData;
            if (sysHit(cpurf_pkg::SYS_CACHE_CTRL)) cacheCtrl_reg <= sysWriteData;
            if (sysHit(cpurf_pkg::SYS_ADDR_TRAP)) addrTrap_reg <= sysWriteData;
        end
    end

    // System read select; identity is a constant, unused numbers read zero
    always_comb begin
        unique case (sysReadIndex)
            cpurf_pkg::SYS_EXC_PC: sysRead_next = excPc_reg;
            cpurf_pkg::SYS_EXC_STATUS: sysRead_next = excStatus_reg;
            cpurf_pkg::SYS_FATAL_PC: sysRead_next = fatalPc_reg;
            cpurf_pkg::SYS_FATAL_STATUS: sysRead_next = fatalStatus_reg;
            cpurf_pkg::SYS_CAUSE: sysRead_next = cause_reg;
            cpurf_pkg::SYS_STATUS: sysRead_next = status_reg;
            cpurf_pkg::SYS_IDENTITY: sysRead_next = cpurf_pkg::IDENTITY_VALUE;
            cpurf_pkg::SYS_TASK_CTRL: sysRead_next = taskCtrl_reg;
            cpurf_pkg::SYS_CACHE_CTRL: sysRead_next = cacheCtrl_reg;
            cpurf_pkg::SYS_ADDR_TRAP: sysRead_next = addrTrap_reg;
            default: sysRead_next = cpurf_pkg::ZERO_WORD;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sysRead_reg <= cpurf_pkg::ZERO_WORD;
        end else begin
            sysRead_reg <= sysRead_next;
        end
    end

    assign sysReadData = sysRead_reg;
    assign programStatusWord = status_reg;
    assign taskControlWord = taskCtrl_reg;
    assign cacheControlWord = cacheCtrl_reg;
    assign addressTrapWord = addrTrap_reg;
endmodule // cpurf_register_file

/* tb/cpurf_register_file_chk.sv */
// Port-level concurrent checks for the CPU register file
`timescale 1ns/1ps
module cpurf_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [4:0] readIndexA,
    input wire logic [31:0] readDataA,
    input wire logic gprWriteEn,
    input wire logic [4:0] gprWriteIndex,
    input wire logic [31:0] gprWriteData,
    input wire logic jumpAndLinkOp,
    input wire logic [31:0] returnAddress,
    input wire logic pcLoadEn,
    input wire logic [31:0] pcLoadValue,
    input wire logic [31:0] programCounter,
    input wire logic exceptionTake,
    input wire logic fatalTake,
    input wire logic sysWriteEn,
    input wire logic [4:0] sysReadIndex,
    input wire logic [31:0] sysReadData,
    input wire logic [31:0] strDstBitOffset
);
    // One clock domain, reset masks every check
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_pc_even: assert property (programCounter[0] == 1'b0)
        else $error("pc bit 0 set");
    a_pc_reset: assert property ($past(rst) |-> programCounter == cpurf_pkg::PC_RESET)
        else $error("pc reset value wrong");
    a_pc_load: assert property (pcLoadEn
        |=> programCounter == {$past(pcLoadValue[31:1]), 1'b0})
        else $error("pc load wrong");
    a_zero_read: assert property (readIndexA == 5'h0 |=> readDataA == 32'h0)
        else $error("index 0 not zero");
    a_str_shadow: assert property (gprWriteEn && !jumpAndLinkOp
        && gprWriteIndex == 5'h1a |=> strDstBitOffset == $past(gprWriteData))
        else $error("bit offset shadow stale");
    // Old-data read on a same-cycle write keeps this one exact
    a_jal_link: assert property (jumpAndLinkOp ##1 readIndexA == 5'h1f
        |=> readDataA == $past(returnAddress, 2))
        else $error("link register wrong");
    a_exc_save: assert property (exceptionTake ##1 (sysReadIndex == 5'h0 && !sysWriteEn
        && !exceptionTake && !fatalTake) |=> sysReadData == $past(programCounter, 2))
        else $error("exception pc not saved");
    a_id_const: assert property (sysReadIndex == 5'h06
        |=> sysReadData == cpurf_pkg::IDENTITY_VALUE)
        else $error("identity word wrong");
    c_jal: cover property (jumpAndLinkOp);
    c_exc: cover property (exceptionTake);
    c_fatal: cover property (fatalTake);
endmodule // cpurf_chk
bind cpurf_register_file cpurf_chk cpurf_chk_inst (
    .mclk(mclk),
    .rst(rst),
    .readIndexA(readIndexA),
    .readDataA(readDataA),
    .gprWriteEn(gprWriteEn),
    .gprWriteIndex(gprWriteIndex),
    .gprWriteData(gprWriteData),
    .jumpAndLinkOp(jumpAndLinkOp),
    .returnAddress(returnAddress),
    .pcLoadEn(pcLoadEn),
    .pcLoadValue(pcLoadValue),
    .programCounter(programCounter),
    .exceptionTake(exceptionTake),
    .fatalTake(fatalTake),
    .sysWriteEn(sysWriteEn),
    .sysReadIndex(sysReadIndex),
    .sysReadData(sysReadData),
    .strDstBitOffset(strDstBitOffset)
);

/* tb/tb_cpu_register_file.sv */
// Self-checking bench for the CPU register file
`timescale 1ns/1ps
module tb_cpu_register_file;
    logic mclk = 1'b0, rst = 1'b1, gprWriteEn = 1'b0, jumpAndLinkOp = 1'b0, pcLoadEn = 1'b0;
    logic exceptionTake = 1'b0, fatalTake = 1'b0, sysWriteEn = 1'b0;
    logic [4:0] readIndexA = 5'h0, readIndexB = 5'h0, gprWriteIndex = 5'h0;
    logic [4:0] sysWriteIndex = 5'h0, sysReadIndex = 5'h0;
    logic [31:0] gprWriteData = 32'h0, returnAddress = 32'h0, pcLoadValue = 32'h0;
    logic [31:0] causeValue = 32'h0, sysWriteData = 32'h0;
    logic [31:0] readDataA, readDataB, programCounter, sysReadData, programStatusWord;
    logic [31:0] taskControlWord, cacheControlWord, addressTrapWord, zeroOperand;
    logic [31:0] strDstBitOffset, strSrcBitOffset, strLength, strDstAddress, strSrcAddress;
    int fails = 0, n_compared = 0;
    cpurf_register_file cpurf_register_file_inst (
        .mclk(mclk),
        .rst(rst),
        .readIndexA(readIndexA),
        .readIndexB(readIndexB),
        .readDataA(readDataA),
        .readDataB(readDataB),
        .gprWriteEn(gprWriteEn),
        .gprWriteIndex(gprWriteIndex),
        .gprWriteData(gprWriteData),
        .jumpAndLinkOp(jumpAndLinkOp),
        .returnAddress(returnAddress),
        .pcLoadEn(pcLoadEn),
        .pcLoadValue(pcLoadValue),
        .programCounter(programCounter),
        .exceptionTake(exceptionTake),
        .fatalTake(fatalTake),
        .causeValue(causeValue),
        .sysWriteEn(sysWriteEn),
        .sysWriteIndex(sysWriteIndex),
        .sysWriteData(sysWriteData),
        .sysReadIndex(sysReadIndex),
        .sysReadData(sysReadData),
        .programStatusWord(programStatusWord),
        .taskControlWord(taskControlWord),
        .cacheControlWord(cacheControlWord),
        .addressTrapWord(addressTrapWord),
        .strDstBitOffset(strDstBitOffset),
        .strSrcBitOffset(strSrcBitOffset),
        .strLength(strLength),
        .strDstAddress(strDstAddress),
        .strSrcAddress(strSrcAddress),
        .zeroOperand(zeroOperand)
    );
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Inputs move only on the falling edge
    task automatic step;
        @(negedge mclk);
    endtask
    function automatic logic [31:0] pat(input logic [4:0] i);
        return {3'h5, i, 24'h00c3a5};
    endfunction
    // Caller drops the enable, so back-to-back writes never toggle it
    task automatic gwr(input logic [4:0] i, input logic [31:0] d);
        gprWriteEn = 1'b1;
        gprWriteIndex = i;
        gprWriteData = d;
        step();
    endtask
    task automatic grd(input logic [4:0] i, input logic [31:0] e);
        readIndexA = i;
        readIndexB = i;
        step();
        chk(readDataA, e);
        chk(readDataB, e);
    endtask
    task automatic swr(input logic [4:0] i, input logic [31:0] d);
        sysWriteEn = 1'b1;
        sysWriteIndex = i;
        sysWriteData = d;
        step();
    endtask
    task automatic srd(input logic [4:0] i, input logic [31:0] e);
        sysReadIndex = i;
        step();
        chk(sysReadData, e);
    endtask
    task automatic pld(input logic [31:0] v);
        pcLoadEn = 1'b1;
        pcLoadValue = v;
        step();
        pcLoadEn = 1'b0;
    endtask
    task automatic t_reset;
        chk(programCounter, cpurf_pkg::PC_RESET);
        chk(programStatusWord, 32'h0);
        chk(strLength, 32'h0);
    endtask
    task automatic t_gpr;
        for (int i = 0; i < 32; i++) begin
            gwr(i[4:0], pat(i[4:0]));
        end
        gprWriteEn = 1'b0;
        chk(strDstBitOffset, pat(5'h1a));
        chk(strSrcBitOffset, pat(5'h1b));
        chk(strLength, pat(5'h1c));
        chk(strDstAddress, pat(5'h1d));
        chk(strSrcAddress, pat(5'h1e));
        for (int i = 0; i < 32; i++) begin
            grd(i[4:0], (i == 0) ? 32'h0 : pat(i[4:0]));
        end
        chk(zeroOperand, 32'h0);
    endtask
    // Link write wins over an ordinary write in the same cycle
    task automatic t_jal;
        jumpAndLinkOp = 1'b1;
        returnAddress = 32'h00c0ffee;
        gwr(5'h1f, 32'h0badf00d);
        gprWriteEn = 1'b0;
        jumpAndLinkOp = 1'b0;
        grd(5'h1f, 32'h00c0ffee);
    endtask
    task automatic t_sys;
        pld(32'h12345679);
        chk(programCounter, 32'h12345678);
        swr(5'h05, 32'h1234abcd);
        swr(5'h07, 32'h00000071);
        swr(5'h18, 32'h00000018);
        swr(5'h19, 32'h00000019);
        swr(5'h06, 32'hffffffff);
        sysWriteEn = 1'b0;
        chk(programStatusWord, 32'h1234abcd);
        chk(taskControlWord, 32'h00000071);
        chk(cacheControlWord, 32'h00000018);
        chk(addressTrapWord, 32'h00000019);
        srd(5'h06, cpurf_pkg::IDENTITY_VALUE);
        srd(5'h18, 32'h00000018);
        srd(5'h08, 32'h00000000);
    endtask
    // Status write in the exception cycle must be ignored
    task automatic t_exc;
        exceptionTake = 1'b1;
        causeValue = 32'h0000ff90;
        swr(5'h05, 32'h0);
        sysWriteEn = 1'b0;
        exceptionTake = 1'b0;
        srd(5'h00, 32'h12345678);
        srd(5'h01, 32'h1234abcd);
        srd(5'h04, 32'h0000ff90);
        pld(32'h00000a02);
        fatalTake = 1'b1;
        step();
        fatalTake = 1'b0;
        srd(5'h02, 32'h00000a02);
        srd(5'h03, 32'h1234abcd);
        srd(5'h00, 32'h12345678);
    endtask
    // Mid-run reset must bring back the start address after the PC has moved
    task automatic t_rst;
        rst = 1'b1;
        step();
        rst = 1'b0;
        chk(programCounter, cpurf_pkg::PC_RESET);
        chk(programStatusWord, 32'h0);
        chk(strLength, 32'h0);
        srd(5'h00, 32'h0);
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        t_reset();
        t_gpr();
        t_jal();
        t_sys();
        t_exc();
        t_rst();
        conclude();
    end
endmodule // tb_cpu_register_file
